// ---- ocal_calib.sv ----
// output current gain and per-phase offset trim with word command access
`timescale 1ns/1ps
module ocal_calib (
  input  wire logic               CLOCK,
  input  wire logic               RST_N,
  input  wire logic [7:0]         CMD_CODE,
  input  wire logic               WR_STROBE,
  input  wire logic               RD_STROBE,
  input  wire logic [15:0]        WR_DATA,
  input  wire logic [7:0]         PHASE,
  input  wire logic [2:0]         NUM_PHASES,
  input  wire logic               NVM_STORE,
  input  wire logic               NVM_RESTORE,
  input  wire logic               SENSE_VALID,
  input  wire logic signed [15:0] SENSE_CURRENT,
  output logic [15:0]             RD_DATA,
  output logic                    RD_VALID,
  output logic                    INVALID_DATA,
  output logic signed [15:0]      IOUT,
  output logic                    IOUT_VALID
);
  ocal_pkg::ocal_word_t gain_word_ff, nxt_gain_word;
  ocal_pkg::ocal_word_t gain_nvm_ff, nxt_gain_nvm;
  ocal_pkg::ocal_word_t ofs_word_ff [ocal_pkg::NPH];
  ocal_pkg::ocal_word_t nxt_ofs_word [ocal_pkg::NPH];
  ocal_pkg::ocal_word_t ofs_nvm_ff [ocal_pkg::NPH];
  ocal_pkg::ocal_word_t nxt_ofs_nvm [ocal_pkg::NPH];
  logic [15:0]          rd_data_ff, nxt_rd_data;
  logic                 rd_valid_ff, nxt_rd_valid;
  logic                 invalid_ff, nxt_invalid;
  logic signed [15:0]   iout_ff, nxt_iout;
  logic                 iout_valid_ff, nxt_iout_valid;

  ocal_pkg::ocal_fix_t  gain_fix, wr_fix;
  ocal_pkg::ocal_fix_t  ofs_fix [ocal_pkg::NPH];
  logic                 gain_oor, wr_oor;
  logic [2:0]           nph;
  logic signed [31:0]   nph_s;

  ocal_lin2fix u_gain_conv (
    .word         (gain_word_ff),
    .fix          (gain_fix),
    .out_of_range (gain_oor)
  );

  ocal_lin2fix u_wr_conv (
    .word         (WR_DATA),
    .fix          (wr_fix),
    .out_of_range (wr_oor)
  );

  for (genvar p = 0; p < ocal_pkg::NPH; p++) begin : g_ofs
    ocal_lin2fix u_ofs_conv (
      .word         (ofs_word_ff[p]),
      .fix          (ofs_fix[p]),
      .out_of_range ()
    );
  end

  // a phase count of zero is treated as a lone phase
  assign nph   = (NUM_PHASES == 3'h0) ? 3'h1 : ((NUM_PHASES > 3'h4) ? 3'h4 : NUM_PHASES);
  assign nph_s = {29'h0, nph};

  // divide a mantissa by the phase count, truncating toward zero
  function automatic logic [10:0] div_man(input logic [10:0] m, input logic [2:0] n);
    logic signed [10:0] s;
    s = $signed(m);
    unique case (n)
      3'h2:    div_man = 11'(s / 11'sh002);
      3'h3:    div_man = 11'(s / 11'sh003);
      3'h4:    div_man = 11'(s / 11'sh004);
      default: div_man = m;
    endcase
  endfunction : div_man

  // scale a word by the phase count, renormalising the mantissa into 11 bits
  function automatic logic [15:0] mul_word(input logic [15:0] w, input logic [2:0] n);
    logic signed [13:0] prod;
    logic [4:0]         e;
    prod = 14'($signed(w[10:0]) * $signed({1'b0, n}));
    e    = w[15:11];
    if (prod >= -14'sh0400 && prod <= 14'sh03ff) begin
      mul_word = {e, prod[10:0]};
    end else if ((prod >>> 1) >= -14'sh0400 && (prod >>> 1) <= 14'sh03ff) begin
      mul_word = {5'(e + 5'h01), 11'(prod >>> 1)};
    end else begin
      mul_word = {5'(e + 5'h02), 11'(prod >>> 2)};
    end
  endfunction : mul_word

  // trim register file and command handling
  always_comb begin
    logic signed [31:0] q;
    logic signed [31:0] tot_min;
    logic signed [31:0] tot_max;
    logic               ofs_ok;
    q              = '0;
    tot_min        = 32'(ocal_pkg::OFS_MIN * nph_s);
    tot_max        = 32'(ocal_pkg::OFS_MAX * nph_s);
    ofs_ok         = 1'b0;
    nxt_gain_word  = gain_word_ff;
    nxt_gain_nvm   = gain_nvm_ff;
    nxt_ofs_word   = ofs_word_ff;
    nxt_ofs_nvm    = ofs_nvm_ff;
    nxt_rd_data    = rd_data_ff;
    nxt_rd_valid   = 1'b0;
    nxt_invalid    = 1'b0;

    if (NVM_STORE) begin
      // gain snapped to the 1/64 grid and capped at 127/64
      q = (gain_fix + 32'sh0000_0008) >>> ocal_pkg::GAIN_NVM_SHIFT;
      if (q > ocal_pkg::GAIN_NVM_MAX) q = ocal_pkg::GAIN_NVM_MAX;
      if (q < 32'sh0) q = 32'sh0;
      nxt_gain_nvm = {ocal_pkg::GAIN_NVM_EXP, q[10:0]};
      for (int p = 0; p < ocal_pkg::NPH; p++) begin
        q = (ofs_fix[p] + 32'sh0000_0020) >>> ocal_pkg::OFFSET_NVM_SHIFT;
        if (q > ocal_pkg::OFS_NVM_MAX) q = ocal_pkg::OFS_NVM_MAX;
        if (q < ocal_pkg::OFS_NVM_MIN) q = ocal_pkg::OFS_NVM_MIN;
        nxt_ofs_nvm[p] = {ocal_pkg::OFFSET_NVM_EXP, q[10:0]};
      end
    end

    if (NVM_RESTORE) begin
      nxt_gain_word = gain_nvm_ff;
      nxt_ofs_word  = ofs_nvm_ff;
    end else if (WR_STROBE && CMD_CODE == ocal_pkg::CMD_GAIN) begin
      // a negative or 2x-and-above gain has no meaning for the telemetry path
      if (wr_oor || wr_fix < 32'sh0 || wr_fix >= ocal_pkg::GAIN_MAX_EXCL) begin
        nxt_invalid = 1'b1;
      end else begin
        nxt_gain_word = WR_DATA;
      end
    end else if (WR_STROBE && CMD_CODE == ocal_pkg::CMD_OFFSET) begin
      if (PHASE == ocal_pkg::PHASE_ALL) begin
        ofs_ok = !wr_oor && wr_fix >= tot_min && wr_fix <= tot_max;
        if (ofs_ok) begin
          for (int p = 0; p < ocal_pkg::NPH; p++) begin
            nxt_ofs_word[p] = {WR_DATA[15:11], div_man(WR_DATA[10:0], nph)};
          end
        end
      end else if (PHASE < 8'(ocal_pkg::NPH)) begin
        ofs_ok = !wr_oor && wr_fix >= ocal_pkg::OFS_MIN && wr_fix <= ocal_pkg::OFS_MAX;
        if (ofs_ok) nxt_ofs_word[PHASE[1:0]] = WR_DATA;
      end
      nxt_invalid = !ofs_ok;
    end

    if (RD_STROBE) begin
      nxt_rd_valid = 1'b1;
      if (CMD_CODE == ocal_pkg::CMD_GAIN) begin
        nxt_rd_data = gain_word_ff;
      end else if (CMD_CODE == ocal_pkg::CMD_OFFSET && PHASE == ocal_pkg::PHASE_ALL) begin
        nxt_rd_data = mul_word(ofs_word_ff[0], nph);
      end else if (CMD_CODE == ocal_pkg::CMD_OFFSET && PHASE < 8'(ocal_pkg::NPH)) begin
        nxt_rd_data = ofs_word_ff[PHASE[1:0]];
      end else begin
        // unknown command or phase answers zero and is flagged
        nxt_rd_data = 16'h0000;
        nxt_invalid = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      gain_word_ff <= {ocal_pkg::GAIN_EXP_RST, ocal_pkg::GAIN_MAN_RST};
      gain_nvm_ff  <= {ocal_pkg::GAIN_EXP_RST, ocal_pkg::GAIN_MAN_RST};
      for (int p = 0; p < ocal_pkg::NPH; p++) begin
        ofs_word_ff[p] <= {ocal_pkg::OFFSET_EXP_RST, ocal_pkg::OFFSET_MAN_RST};
        ofs_nvm_ff[p]  <= {ocal_pkg::OFFSET_EXP_RST, ocal_pkg::OFFSET_MAN_RST};
      end
      rd_data_ff   <= 16'h0000;
      rd_valid_ff  <= 1'b0;
      invalid_ff   <= 1'b0;
    end else begin
      gain_word_ff <= nxt_gain_word;
      gain_nvm_ff  <= nxt_gain_nvm;
      ofs_word_ff  <= nxt_ofs_word;
      ofs_nvm_ff   <= nxt_ofs_nvm;
      rd_data_ff   <= nxt_rd_data;
      rd_valid_ff  <= nxt_rd_valid;
      invalid_ff   <= nxt_invalid;
    end
  end

  // telemetry path: sense * gain + sum of active phase offsets
  always_comb begin
    logic signed [47:0] scaled;
    logic signed [31:0] ofs_sum;
    scaled  = 48'(48'(SENSE_CURRENT) * 48'(gain_fix)) >>> ocal_pkg::FRAC;
    ofs_sum = 32'sh0;
    for (int p = 0; p < ocal_pkg::NPH; p++) begin
      if (3'(p) < nph) ofs_sum = ofs_sum + ofs_fix[p];
    end
    // truncation, not saturation: caller keeps sensed range inside 16 bits
    nxt_iout       = iout_ff;
    nxt_iout_valid = SENSE_VALID;
    if (SENSE_VALID) begin
      nxt_iout = 16'(scaled[31:0] + (ofs_sum >>> (ocal_pkg::FRAC - ocal_pkg::TEL_FRAC)));
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      iout_ff       <= 16'sh0000;
      iout_valid_ff <= 1'b0;
    end else begin
      iout_ff       <= nxt_iout;
      iout_valid_ff <= nxt_iout_valid;
    end
  end

  assign RD_DATA      = rd_data_ff;
  assign RD_VALID     = rd_valid_ff;
  assign INVALID_DATA = invalid_ff;
  assign IOUT         = iout_ff;
  assign IOUT_VALID   = iout_valid_ff;
endmodule : ocal_calib

// ---- ocal_calib_bench.sv ----
// self-checking bench for the current calibration stage
`timescale 1ns/1ps
module ocal_calib_bench;
  localparam logic [7:0] gcmd = ocal_pkg::CMD_GAIN;
  localparam logic [7:0] ocmd = ocal_pkg::CMD_OFFSET;
  logic        clock, rst_n, wr, rd, st, rs, sv, rv, inv, iv;
  logic [7:0]  cmd, ph;
  logic [2:0]  np;
  logic [15:0] wd, rdat;
  logic signed [15:0] cur, iout;
  int          errors, check_count, seed, gn, gs;
  int          ofs[4];
  int          gv[2] = '{255, 129};
  ocal_host u_host (.CLOCK(clock), .RD_DATA(rdat), .RD_VALID(rv), .INVALID_DATA(inv),
    .CMD_CODE(cmd), .WR_STROBE(wr), .RD_STROBE(rd), .WR_DATA(wd), .PHASE(ph));
  ocal_calib u_dut (.CLOCK(clock), .RST_N(rst_n), .CMD_CODE(cmd), .WR_STROBE(wr),
    .RD_STROBE(rd), .WR_DATA(wd), .PHASE(ph), .NUM_PHASES(np), .NVM_STORE(st),
    .NVM_RESTORE(rs), .SENSE_VALID(sv), .SENSE_CURRENT(cur), .RD_DATA(rdat),
    .RD_VALID(rv), .INVALID_DATA(inv), .IOUT(iout), .IOUT_VALID(iv));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done;
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // write: e is the expected invalid flag; read: e is the expected word
  task automatic op(input logic w, input logic [7:0] c, p, input logic [15:0] d, e);
    logic [15:0] r;
    logic        v, i;
    logic        bad;
    // reads of an unknown command or phase answer zero and raise the invalid pulse
    bad = !(c == gcmd || (c == ocmd && (p < 8'h04 || p == 8'hff)));
    u_host.xfer(w, c, p, d, r, v, i);
    if (w) begin
      chk("invalid", {15'h0, i}, e);
    end else begin
      chk("read", r, e);
      chk("read_valid", {15'h0, v}, 16'h0001);
      chk("read_invalid", {15'h0, i}, {15'h0, bad});
    end
  endtask : op
  // offsets are whole 1/16 A, so dropping fine gain bits first is exact
  function automatic logic [15:0] exp_iout(input int s);
    int t;
    int n;
    t = (s * gn) >>> gs;
    // a phase count of zero counts as one, above four as four
    n = (np == 3'h0) ? 1 : ((np > 3'h4) ? 4 : int'(np));
    for (int k = 0; k < n; k++) t += ofs[k];
    return t[15:0];
  endfunction : exp_iout
  task automatic samp;
    @(posedge clock);
    sv  <= 1'b1;
    cur <= 16'($random(seed) % 2000);
    @(posedge clock);
    sv <= 1'b0;
    #1 chk("iout", iout, exp_iout(cur));
    chk("iout_valid", {15'h0, iv}, 16'h0001);
  endtask : samp
  task automatic nv(input logic s);
    @(posedge clock);
    st <= s;
    rs <= !s;
    @(posedge clock);
    st <= 1'b0;
    rs <= 1'b0;
  endtask : nv
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done();
  end
  initial begin
    seed        = 17663;
    errors      = 0;
    check_count = 0;
    rst_n       = 1'b0;
    {st, rs, sv} = 3'h0;
    cur         = 16'sh0000;
    np = 3'h4;
    gn = 128;
    gs = 7;
    ofs = '{0, 0, 0, 0};
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    op(0, gcmd, 0, 0, 16'hc880);
    op(0, ocmd, 0, 0, 16'he000);
    samp();
    repeat (6) begin
      // whole 3-bit range, so the zero and above-four clamps are reached too
      @(posedge clock) np <= 3'({$random(seed)} % 8);
      gn = {$random(seed)} % 256;
      op(1, gcmd, 0, {5'h19, 11'(gn)}, 0);
      for (int k = 0; k < 4; k++) begin
        ofs[k] = $random(seed) % 128;
        op(1, ocmd, 8'(k), {5'h1c, 11'(ofs[k])}, 0);
      end
      op(0, gcmd, 0, 0, {5'h19, 11'(gn)});
      for (int k = 0; k < 4; k++) op(0, ocmd, 8'(k), 0, {5'h1c, 11'(ofs[k])});
      samp();
    end
    @(posedge clock) np <= 3'h4;
    op(1, ocmd, 8'hff, 16'he7f9, 0);
    ofs = '{-1, -1, -1, -1};
    op(0, ocmd, 8'h02, 0, 16'he7ff);
    op(0, ocmd, 8'hff, 0, 16'he7fc);
    op(1, ocmd, 8'h01, 16'he780, 0);
    ofs[1] = -128;
    op(1, ocmd, 8'h02, 16'he07f, 0);
    ofs[2] = 127;
    op(1, ocmd, 8'h03, 16'h0008, 1);
    op(1, ocmd, 8'h04, 16'he001, 1);
    op(0, ocmd, 8'h04, 0, 16'h0000);
    op(1, 8'h40, 0, 16'h1234, 0);
    op(0, 8'h40, 0, 0, 16'h0000);
    op(1, gcmd, 0, 16'hcfff, 1);
    op(0, ocmd, 8'h03, 0, 16'he7ff);
    samp();
    foreach (gv[i]) begin
      gn = gv[i];
      gs = 7;
      op(1, gcmd, 0, {5'h19, 11'(gn)}, 0);
      nv(1'b1);
      op(1, gcmd, 0, 16'hc801, 0);
      op(1, ocmd, 0, 16'he001, 0);
      nv(1'b0);
      gn = ((gn + 1) >>> 1) > 127 ? 127 : (gn + 1) >>> 1;
      gs = 6;
      op(0, gcmd, 0, 0, {5'h1a, 11'(gn)});
      op(0, ocmd, 0, 0, 16'he7ff);
      samp();
    end
    @(posedge clock) rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    op(0, gcmd, 0, 0, 16'hc880);
    op(0, ocmd, 8'h01, 0, 16'he000);
    test_done();
  end
endmodule : ocal_calib_bench

// ---- ocal_host.sv ----
// word-access host model for the command port
`timescale 1ns/1ps
module ocal_host (
  input  wire logic        CLOCK,
  input  wire logic [15:0] RD_DATA,
  input  wire logic        RD_VALID,
  input  wire logic        INVALID_DATA,
  output logic [7:0]       CMD_CODE,
  output logic             WR_STROBE,
  output logic             RD_STROBE,
  output logic [15:0]      WR_DATA,
  output logic [7:0]       PHASE
);
  initial {CMD_CODE, WR_STROBE, RD_STROBE, WR_DATA, PHASE} = '0;
  task automatic xfer(input logic w, input logic [7:0] c, p, input logic [15:0] d,
                      output logic [15:0] q, output logic v, i);
    @(posedge CLOCK);
    WR_STROBE <= w;
    RD_STROBE <= !w;
    CMD_CODE  <= c;
    PHASE     <= p;
    WR_DATA   <= d;
    @(posedge CLOCK);
    WR_STROBE <= 1'b0;
    RD_STROBE <= 1'b0;
    // idle bus shows no stale word
    WR_DATA   <= ~d;
    #1;
    q = RD_DATA;
    v = RD_VALID;
    i = INVALID_DATA;
  endtask : xfer
endmodule : ocal_host

// ---- ocal_lin2fix.sv ----
// converts a signed linear 11-bit-mantissa word into internal fixed point
`timescale 1ns/1ps
module ocal_lin2fix (
  input  wire logic [15:0]      word,
  output ocal_pkg::ocal_fix_t   fix,
  output logic                  out_of_range
);
  logic signed [47:0] m48;
  logic signed [47:0] v;
  int                 sh;

  always_comb begin
    m48 = {{37{word[ocal_pkg::MAN_MSB]}}, word[ocal_pkg::MAN_MSB:0]};
    sh  = int'($signed(word[ocal_pkg::EXP_MSB:ocal_pkg::EXP_LSB])) + ocal_pkg::FRAC;
    if (sh >= 0) begin
      v = m48 <<< sh;
    end else begin
      v = m48 >>> (-sh);
    end
    fix          = v[31:0];
    // anything that does not fit 32 bits is far outside every accepted range
    out_of_range = !((&v[47:31]) || !(|v[47:31]));
  end
endmodule : ocal_lin2fix

// ---- ocal_pkg.sv ----
// constants and types for the output current calibration stage
package ocal_pkg;
  localparam logic [7:0]  CMD_GAIN        = 8'h38;
  localparam logic [7:0]  CMD_OFFSET      = 8'h39;
  localparam logic [7:0]  PHASE_ALL       = 8'hff;
  localparam int          NPH             = 4;
  localparam int          EXP_MSB         = 15;
  localparam int          EXP_LSB         = 11;
  localparam int          MAN_MSB         = 10;
  // internal fixed point: value scaled by 2**FRAC
  localparam int          FRAC            = 10;
  // telemetry current units are 1/16 A
  localparam int          TEL_FRAC        = 4;
  localparam logic [4:0]  GAIN_EXP_RST    = 5'h19;
  localparam logic [10:0] GAIN_MAN_RST    = 11'h080;
  localparam logic [4:0]  OFFSET_EXP_RST  = 5'h1c;
  localparam logic [10:0] OFFSET_MAN_RST  = 11'h000;
  // accepted gain lies in [0, 2)
  localparam logic signed [31:0] GAIN_MAX_EXCL = 32'sh0000_0800;
  localparam logic signed [31:0] OFS_MIN       = -32'sh0000_2000;
  localparam logic signed [31:0] OFS_MAX       = 32'sh0000_1fc0;
  // restore grids: gain in 1/64 steps, offset in 1/16 A steps
  localparam logic [4:0]  GAIN_NVM_EXP    = 5'h1a;
  localparam int          GAIN_NVM_SHIFT  = 4;
  localparam logic signed [31:0] GAIN_NVM_MAX  = 32'sh0000_007f;
  localparam logic [4:0]  OFFSET_NVM_EXP  = 5'h1c;
  localparam int          OFFSET_NVM_SHIFT = 6;
  localparam logic signed [31:0] OFS_NVM_MIN   = -32'sh0000_0080;
  localparam logic signed [31:0] OFS_NVM_MAX   = 32'sh0000_007f;
  typedef logic signed [31:0] ocal_fix_t;
  typedef logic [15:0] ocal_word_t;
endpackage : ocal_pkg

// ---- ocal_sva.sv ----
// port assertions for the current calibration stage
`timescale 1ns/1ps
module ocal_sva (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic [7:0]  CMD_CODE,
  input wire logic        WR_STROBE,
  input wire logic        RD_STROBE,
  input wire logic [15:0] WR_DATA,
  input wire logic [7:0]  PHASE,
  input wire logic        NVM_RESTORE,
  input wire logic        SENSE_VALID,
  input wire logic [15:0] RD_DATA,
  input wire logic        RD_VALID,
  input wire logic        INVALID_DATA,
  input wire logic signed [15:0] IOUT,
  input wire logic        IOUT_VALID
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire w_ok = WR_STROBE && !NVM_RESTORE;
  a_read_answer: assert property (RD_STROBE |=> RD_VALID) else $error("read unanswered");
  a_read_hold: assert property (!RD_STROBE |=> !RD_VALID && $stable(RD_DATA))
    else $error("read data moved");
  a_sample_answer: assert property (SENSE_VALID |=> IOUT_VALID) else $error("no sample");
  a_sample_hold: assert property (!SENSE_VALID |=> !IOUT_VALID && $stable(IOUT))
    else $error("current moved");
  a_gain_negative: assert property (w_ok && CMD_CODE == ocal_pkg::CMD_GAIN
    && WR_DATA[10] |=> INVALID_DATA) else $error("negative gain taken");
  a_offset_high: assert property (w_ok && CMD_CODE == ocal_pkg::CMD_OFFSET && PHASE < 8'h04
    && WR_DATA[15:11] == 5'h00 && !WR_DATA[10] && WR_DATA[9:3] != 7'h00 |=> INVALID_DATA)
    else $error("offset above range taken");
  a_phase_steer: assert property (w_ok && CMD_CODE == ocal_pkg::CMD_OFFSET
    && PHASE inside {[8'h04:8'hfe]} |=> INVALID_DATA) else $error("bad phase taken");
  a_idle_quiet: assert property (!WR_STROBE && !RD_STROBE |=> !INVALID_DATA)
    else $error("spurious invalid");
endmodule : ocal_sva
bind ocal_calib ocal_sva u_sva (.CLOCK, .RST_N, .CMD_CODE, .WR_STROBE, .RD_STROBE, .WR_DATA,
  .PHASE, .NVM_RESTORE, .SENSE_VALID, .RD_DATA, .RD_VALID, .INVALID_DATA, .IOUT, .IOUT_VALID);
